/* hdl/enhanced_dma_map.vh */
// register offsets, field positions and constants of the four-channel dma
`ifndef ENHANCED_DMA_MAP_VH
`define ENHANCED_DMA_MAP_VH
// channel register index within a channel window (addr[2:0])
`define REG_CTRL 3'h0
`define REG_SRC 3'h1
`define REG_DST 3'h2
`define REG_CNT 3'h3
`define REG_MATCH 3'h4
`define REG_STATUS 3'h5
// global registers (addr[5] set)
`define REG_MODE 6'h20
`define REG_PRIO 6'h21
// control field positions
`define CTL_EN 0
`define CTL_B2 1
`define CTL_REP 2
`define CTL_TRIG 3
`define CTL_SINC 5
`define CTL_DINC 6
`define CTL_SRL 7
`define CTL_DRL 9
`define CTL_LINK 11
`define CTL_CRC 12
`define CTL_MATCH 13
`define CTL_DIE 14
`define CTL_EIE 15
// status field positions
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ERR 2
`define ST_HIT 3
`define ST_SWTRIG 4
// trigger sources
`define TRIG_SW 2'h0
`define TRIG_PER 2'h1
`define TRIG_EVT 2'h2
// reload points
`define RL_NONE 2'h0
`define RL_BURST 2'h1
`define RL_BLOCK 2'h2
`define RL_TRANS 2'h3
// block of 64KB when count field is zero
`define BLOCK_MAX 17'h10000
// read-only eeprom window
`define EE_BASE 16'h1000
`define EE_END 16'h13ff
`endif

/* hdl/enhanced_dma.v */
// four-channel dma engine with register port, read and write masters
`include "enhanced_dma_map.vh"
`default_nettype none
module enhanced_dma (
  input wire clk_i,
  input wire reset_i,
  input wire [5:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire [3:0] per_req_i,
  input wire [3:0] event_i,
  output wire rd_req_o,
  output reg [15:0] rd_addr_o,
  input wire rd_ack_i,
  input wire [7:0] rd_data_i,
  output wire wr_valid_o,
  output wire [15:0] wr_addr_o,
  output wire [7:0] wr_data_o,
  input wire wr_ready_i,
  output reg crc_valid_o,
  output reg [7:0] crc_data_o,
  output wire [3:0] irq_o
);
  localparam S_IDLE = 2'h0;
  localparam S_RD = 2'h1;
  localparam S_PUSH = 2'h2;
  ////////////////////////////////////////////////////////////////////////
  // channel state
  reg [15:0] ctrl [0:3];
  reg [15:0] src_start [0:3];
  reg [15:0] dst_start [0:3];
  reg [15:0] cnt [0:3];
  reg [15:0] src_cur [0:3];
  reg [15:0] dst_cur [0:3];
  reg [7:0] match [0:3];
  reg [16:0] remain [0:3];
  reg [3:0] go;
  reg [3:0] rep_used;
  reg [3:0] done_f;
  reg [3:0] err_f;
  reg [3:0] hit_f;
  reg [1:0] mode;
  reg [7:0] prio;
  reg [3:0] req_m;
  reg [3:0] req_s;
  reg [3:0] ev_m;
  reg [3:0] ev_s;
  reg [3:0] ev_d;
  reg [1:0] state;
  reg [1:0] ach;
  reg bcnt;
  reg first_ok;
  reg [7:0] data_q;
  // write buffer
  reg [23:0] fifo [0:1];
  reg wp;
  reg rp;
  reg [1:0] fcnt;
  ////////////////////////////////////////////////////////////////////////
  // selection among channels
  wire [3:0] elig;
  wire [3:0] busy;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      // odd channel of a combined pair is absorbed by its even partner
      wire absorbed = (g % 2 == 1) && mode[g / 2];
      wire [1:0] trig = ctrl[g][`CTL_TRIG+1:`CTL_TRIG];
      assign elig[g] = ctrl[g][`CTL_EN] && go[g] && !absorbed &&
        (trig != `TRIG_PER || req_s[g]);
      assign busy[g] = go[g] || (state != S_IDLE && ach == g);
      assign irq_o[g] = (done_f[g] && ctrl[g][`CTL_DIE]) ||
        (err_f[g] && ctrl[g][`CTL_EIE]);
    end
  endgenerate

  reg [1:0] pick;
  reg found;
  reg [1:0] bestp;
  integer i;
  always @* begin
    pick = 2'h0;
    found = 1'b0;
    bestp = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
      // ties go to the lower channel number
      if (elig[i] && (!found || prio[i*2+:2] > bestp)) begin
        found = 1'b1;
        bestp = prio[i*2+:2];
        pick = i[1:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // per-byte bookkeeping of the active channel
  wire [15:0] actl = ctrl[ach];
  wire std = mode[ach[1]];
  wire b2 = actl[`CTL_B2];
  wire last_b = !b2 || bcnt;
  wire blk_end = (remain[ach] == 17'h1);
  wire again = actl[`CTL_REP] && !rep_used[ach];
  wire [7:0] cmp = (std && bcnt) ? match[{ach[1], 1'b1}] : match[ach];
  // standard pairs with two-byte bursts search a 16-bit value, all others a byte
  wire same = (data_q == cmp);
  wire hit_now = actl[`CTL_MATCH] && same &&
    (!std || !b2 || (bcnt && first_ok));
  wire tr_end = (blk_end && !again) || hit_now;
  wire [1:0] srl = actl[`CTL_SRL+1:`CTL_SRL];
  wire [1:0] drl = actl[`CTL_DRL+1:`CTL_DRL];
  wire src_rl = (srl == `RL_BURST && last_b) ||
    (srl == `RL_BLOCK && blk_end) || (srl == `RL_TRANS && tr_end);
  wire dst_rl = (drl == `RL_BURST && last_b) ||
    (drl == `RL_BLOCK && blk_end) || (drl == `RL_TRANS && tr_end);
  wire [15:0] src_nx = actl[`CTL_SINC] ? src_cur[ach] + 16'h1 :
    src_cur[ach];
  wire [15:0] dst_nx = actl[`CTL_DINC] ? dst_cur[ach] + 16'h1 :
    dst_cur[ach];
  wire push = (state == S_PUSH) && (fcnt != 2'h2);
  wire pop = wr_valid_o && wr_ready_i;
  wire [1:0] nxt = ach + 2'h1;
  // second byte of a burst may step into the eeprom window
  wire dst_two = ctrl[pick][`CTL_B2] && ctrl[pick][`CTL_DINC];
  wire [15:0] dst_hi = dst_cur[pick] + {15'h0, dst_two};
  wire ee_dst = (dst_hi >= `EE_BASE) && (dst_cur[pick] <= `EE_END);

  // bus decode
  wire [1:0] wch = reg_addr_i[4:3];
  wire [2:0] wrg = reg_addr_i[2:0];
  wire chw = reg_wr_i && !reg_addr_i[5];
  wire [16:0] cnt_w = (reg_wdata_i == 16'h0) ? `BLOCK_MAX :
    {1'b0, reg_wdata_i};
  wire [16:0] cnt_nx = (cnt[nxt] == 16'h0) ? `BLOCK_MAX : {1'b0, cnt[nxt]};
  wire [16:0] cnt_a = (cnt[ach] == 16'h0) ? `BLOCK_MAX : {1'b0, cnt[ach]};
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  always @(posedge clk_i) begin
    if (reset_i) begin
      req_m <= 4'h0;
      req_s <= 4'h0;
      ev_m <= 4'h0;
      ev_s <= 4'h0;
      ev_d <= 4'h0;
    end else begin
      req_m <= per_req_i;
      req_s <= req_m;
      ev_m <= event_i;
      ev_s <= ev_m;
      ev_d <= ev_s;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registers and engine; engine updates follow bus writes so engine updates win
  integer k;
  always @(posedge clk_i) begin
    if (reset_i) begin
      for (k = 0; k < 4; k = k + 1) begin
        ctrl[k] <= 16'h0;
        src_start[k] <= 16'h0;
        dst_start[k] <= 16'h0;
        cnt[k] <= 16'h0;
        src_cur[k] <= 16'h0;
        dst_cur[k] <= 16'h0;
        match[k] <= 8'h0;
        remain[k] <= 17'h0;
      end
      go <= 4'h0;
      rep_used <= 4'h0;
      done_f <= 4'h0;
      err_f <= 4'h0;
      hit_f <= 4'h0;
      mode <= 2'h0;
      prio <= 8'h0;
      state <= S_IDLE;
      ach <= 2'h0;
      bcnt <= 1'b0;
      first_ok <= 1'b0;
      data_q <= 8'h0;
      rd_addr_o <= 16'h0;
      crc_valid_o <= 1'b0;
      crc_data_o <= 8'h0;
    end else begin
      crc_valid_o <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        if (ev_s[k] && !ev_d[k] && ctrl[k][`CTL_EN] &&
            ctrl[k][`CTL_TRIG+1:`CTL_TRIG] == `TRIG_EVT) begin
          go[k] <= 1'b1;
        end
      end
      if (reg_wr_i && reg_addr_i == `REG_MODE) begin
        mode <= reg_wdata_i[1:0];
      end else if (reg_wr_i && reg_addr_i == `REG_PRIO) begin
        prio <= reg_wdata_i[7:0];
      end else if (chw && wrg == `REG_CTRL) begin
        ctrl[wch] <= reg_wdata_i;
        src_cur[wch] <= src_start[wch];
        dst_cur[wch] <= dst_start[wch];
        remain[wch] <= (cnt[wch] == 16'h0) ? `BLOCK_MAX : {1'b0, cnt[wch]};
        rep_used[wch] <= 1'b0;
        go[wch] <= reg_wdata_i[`CTL_EN] &&
          reg_wdata_i[`CTL_TRIG+1:`CTL_TRIG] == `TRIG_PER;
      end else if (chw && wrg == `REG_SRC) begin
        src_start[wch] <= reg_wdata_i;
        src_cur[wch] <= reg_wdata_i;
      end else if (chw && wrg == `REG_DST) begin
        dst_start[wch] <= reg_wdata_i;
        dst_cur[wch] <= reg_wdata_i;
      end else if (chw && wrg == `REG_CNT) begin
        cnt[wch] <= reg_wdata_i;
        remain[wch] <= cnt_w;
      end else if (chw && wrg == `REG_MATCH) begin
        match[wch] <= reg_wdata_i[7:0];
      end else if (chw && wrg == `REG_STATUS) begin
        if (reg_wdata_i[`ST_DONE]) done_f[wch] <= 1'b0;
        if (reg_wdata_i[`ST_ERR]) err_f[wch] <= 1'b0;
        if (reg_wdata_i[`ST_HIT]) hit_f[wch] <= 1'b0;
        if (reg_wdata_i[`ST_SWTRIG] && ctrl[wch][`CTL_EN]) begin
          go[wch] <= 1'b1;
        end
      end
      case (state)
        S_IDLE: begin
          if (found) begin
            ach <= pick;
            bcnt <= 1'b0;
            first_ok <= 1'b0;
            if (ee_dst) begin
              // eeprom destination is refused before any byte of the burst moves
              err_f[pick] <= 1'b1;
              go[pick] <= 1'b0;
              ctrl[pick][`CTL_EN] <= 1'b0;
            end else begin
              rd_addr_o <= src_cur[pick];
              state <= S_RD;
            end
          end
        end
        S_RD: begin
          // wait on the read master for whatever latency memory has
          if (rd_ack_i) begin
            data_q <= rd_data_i;
            state <= S_PUSH;
          end
        end
        S_PUSH: begin
          if (push) begin
            crc_valid_o <= actl[`CTL_CRC];
            crc_data_o <= data_q;
            first_ok <= same;
            bcnt <= !bcnt;
            src_cur[ach] <= src_rl ? src_start[ach] : src_nx;
            dst_cur[ach] <= dst_rl ? dst_start[ach] : dst_nx;
            if (tr_end) begin
              remain[ach] <= 17'h0;
              go[ach] <= 1'b0;
              ctrl[ach][`CTL_EN] <= 1'b0;
              done_f[ach] <= 1'b1;
              if (hit_now) hit_f[ach] <= 1'b1;
              if (actl[`CTL_LINK]) begin
                // next channel takes over; software refills this one
                ctrl[nxt][`CTL_EN] <= 1'b1;
                go[nxt] <= 1'b1;
                src_cur[nxt] <= src_start[nxt];
                dst_cur[nxt] <= dst_start[nxt];
                remain[nxt] <= cnt_nx;
                rep_used[nxt] <= 1'b0;
              end
              state <= S_IDLE;
            end else begin
              if (blk_end) begin
                remain[ach] <= cnt_a;
                rep_used[ach] <= 1'b1;
              end else begin
                remain[ach] <= remain[ach] - 17'h1;
              end
              if (last_b) begin
                // sw and event runs keep going; periph waits for request
                state <= S_IDLE;
              end else begin
                // second byte of a burst keeps the bus, no rearbitration
                rd_addr_o <= src_rl ? src_start[ach] : src_nx;
                state <= S_RD;
              end
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign rd_req_o = (state == S_RD);

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer toward the write master
  always @(posedge clk_i) begin
    if (reset_i) begin
      fifo[0] <= 24'h0;
      fifo[1] <= 24'h0;
      wp <= 1'b0;
      rp <= 1'b0;
      fcnt <= 2'h0;
    end else begin
      if (push) begin
        fifo[wp] <= {dst_cur[ach], data_q};
        wp <= !wp;
      end
      if (pop) rp <= !rp;
      if (push && !pop) fcnt <= fcnt + 2'h1;
      else if (pop && !push) fcnt <= fcnt - 2'h1;
    end
  end

  assign wr_valid_o = (fcnt != 2'h0);
  assign wr_addr_o = fifo[rp][23:8];
  assign wr_data_o = fifo[rp][7:0];
  ////////////////////////////////////////////////////////////////////////
  // register read port
  wire [1:0] rch = reg_addr_i[4:3];
  always @(posedge clk_i) begin
    if (reset_i || !reg_rd_i) begin
      reg_rdata_o <= 16'h0;
    end else if (reg_addr_i == `REG_MODE) begin
      reg_rdata_o <= {14'h0, mode};
    end else if (reg_addr_i == `REG_PRIO) begin
      reg_rdata_o <= {8'h0, prio};
    end else if (reg_addr_i[5]) begin
      reg_rdata_o <= 16'h0;
    end else if (reg_addr_i[2:0] == `REG_CTRL) begin
      reg_rdata_o <= ctrl[rch];
    end else if (reg_addr_i[2:0] == `REG_SRC) begin
      reg_rdata_o <= src_cur[rch];
    end else if (reg_addr_i[2:0] == `REG_DST) begin
      reg_rdata_o <= dst_cur[rch];
    end else if (reg_addr_i[2:0] == `REG_CNT) begin
      reg_rdata_o <= remain[rch][15:0];
    end else if (reg_addr_i[2:0] == `REG_MATCH) begin
      reg_rdata_o <= {8'h0, match[rch]};
    end else if (reg_addr_i[2:0] == `REG_STATUS) begin
      reg_rdata_o <= {12'h0, hit_f[rch], err_f[rch], done_f[rch],
        busy[rch]};
    end else begin
      reg_rdata_o <= 16'h0;
    end
  end
endmodule
`default_nettype wire

/* testbench/enhanced_dma_assertions.sv */
// port checker for the four-channel dma engine
`default_nettype none
module enhanced_dma_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic rd_req_o,
  input wire logic [15:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic wr_valid_o,
  input wire logic [15:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic wr_ready_i,
  input wire logic crc_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0)
    else $error("read data not zero outside read slot");
  chk_rdreq_hold: assert property (rd_req_o && !rd_ack_i |=>
    rd_req_o && $stable(rd_addr_o))
    else $error("read request dropped or moved");
  chk_read_gap: assert property (rd_ack_i |=> !rd_req_o)
    else $error("read reissued right after ack");
  chk_req_drop: assert property ($fell(rd_req_o) |-> $past(rd_ack_i))
    else $error("read request fell without ack");
  chk_wr_hold: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("stalled write changed");
  chk_ee_untouched: assert property (wr_valid_o |->
    (wr_addr_o < 16'h1000 || wr_addr_o > 16'h13ff))
    else $error("write aimed at eeprom");
  chk_crc_single: assert property (crc_valid_o |=> !crc_valid_o)
    else $error("crc strobe longer than one cycle");
  // the ack edge, then the push edge, come before the queue shows valid
  chk_push_cause: assert property ($rose(wr_valid_o) |->
    $past(rd_ack_i, 2))
    else $error("write queued without a read");
  cover property (rd_ack_i);
  cover property (rd_req_o && !rd_ack_i);
  cover property (wr_valid_o && !wr_ready_i);
  cover property (crc_valid_o);
endmodule
bind enhanced_dma enhanced_dma_checker enhanced_dma_checker_i (.clk_i,
  .reset_i, .reg_rd_i, .reg_rdata_o, .rd_req_o, .rd_addr_o, .rd_ack_i,
  .wr_valid_o, .wr_addr_o, .wr_data_o, .wr_ready_i, .crc_valid_o);
`default_nettype wire

/* testbench/dma_memory_model.sv */
// memory side model: answers reads, takes writes, may stall
`default_nettype none
module dma_memory_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic stall_i,
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  output logic rd_ack_o,
  output logic [7:0] rd_data_o,
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  output logic [15:0] n_wr_o,
  output logic [15:0] last_addr_o,
  output logic [7:0] last_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_n;
  logic [3:0] need;
  // with slow_i low, eeprom answers one cycle later than sram
  assign need = {2'h0, slow_i, slow_i} +
    {3'h0, rd_addr_i[15:10] == 6'h04};
  always @(posedge clk_i) begin
    // data line holds no value between answers
    rd_data_o <= ~rd_data_o;
    wr_ready_o <= !stall_i;
    if (reset_i || !rd_req_i || rd_ack_o) begin
      wait_n <= 4'h0;
      rd_ack_o <= 1'b0;
    end else if (wait_n >= need) begin
      rd_ack_o <= 1'b1;
      rd_data_o <= rd_addr_i[7:0] ^ 8'ha5;
    end else begin
      wait_n <= wait_n + 4'h1;
    end
    if (reset_i) begin
      n_wr_o <= 16'h0;
    end else if (wr_valid_i && wr_ready_o) begin
      n_wr_o <= n_wr_o + 16'h1;
      last_addr_o <= wr_addr_i;
      last_data_o <= wr_data_i;
    end
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the four-channel dma engine
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] reg_addr_i = 6'h0;
  logic [15:0] reg_wdata_i = 16'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] per_req_i = 4'h0;
  logic [3:0] event_i = 4'h0;
  logic slow = 1'b0;
  logic stall = 1'b0;
  wire [15:0] reg_rdata_o, rd_addr_o, wr_addr_o, n_wr, last_addr;
  wire [7:0] rd_data_i, wr_data_o, last_data, crc_data;
  wire rd_req_o, rd_ack_i, wr_valid_o, wr_ready_i, crc_valid_o;
  wire [3:0] irq_o;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_crc = 0;
  int cyc = 0;
  logic [15:0] crc_sum = 16'h0;
  always #2.5 clk_i = ~clk_i;
  enhanced_dma enhanced_dma_i (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .per_req_i, .event_i, .rd_req_o,
    .rd_addr_o, .rd_ack_i, .rd_data_i, .wr_valid_o, .wr_addr_o, .wr_data_o,
    .wr_ready_i, .crc_valid_o, .crc_data_o(crc_data), .irq_o);
  dma_memory_model dma_memory_model_i (.clk_i, .reset_i, .slow_i(slow),
    .stall_i(stall), .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
    .rd_ack_o(rd_ack_i), .rd_data_o(rd_data_i), .wr_valid_i(wr_valid_o),
    .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .wr_ready_o(wr_ready_i),
    .n_wr_o(n_wr), .last_addr_o(last_addr), .last_data_o(last_data));
  always @(posedge clk_i) begin
    if (crc_valid_o === 1'b1) begin
      n_crc <= n_crc + 1;
      crc_sum <= crc_sum + {8'h0, crc_data};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // bounded wait for the channel flag, then for the write queue to drain
  task automatic wait_done(input int i);
    int n;
    n = 0;
    while ((irq_o[i] !== 1'b1 || wr_valid_o !== 1'b0) && n < 3000) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk({15'h0, irq_o[i]}, 16'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(6'h00, 16'h0);
    rd(6'h3f, 16'h0);
    chk({12'h0, irq_o}, 16'h0);
  endtask
  task automatic t_block;
    logic [15:0] w0;
    w0 = n_wr;
    wr(6'h01, 16'h0100);
    wr(6'h02, 16'h0200);
    wr(6'h03, 16'h0003);
    wr(6'h00, 16'h4265);
    wr(6'h05, 16'h0010);
    wait_done(0);
    chk(n_wr - w0, 16'h6);
    chk(last_addr, 16'h0200);
    chk({8'h0, last_data}, 16'h00a0);
    rd(6'h05, 16'h0002);
    wr(6'h05, 16'h0002);
    rd(6'h05, 16'h0000);
  endtask
  task automatic t_periph;
    logic [15:0] w0;
    logic [15:0] s0;
    int c0;
    w0 = n_wr;
    s0 = crc_sum;
    c0 = n_crc;
    @(posedge clk_i);
    stall <= 1'b1;
    per_req_i <= 4'h2;
    wr(6'h09, 16'h0300);
    wr(6'h0a, 16'h0400);
    wr(6'h0b, 16'h0004);
    wr(6'h08, 16'h502b);
    // hold the far side off long enough to fill the queue
    repeat (40) @(posedge clk_i);
    chk(n_wr - w0, 16'h0);
    chk({15'h0, wr_valid_o}, 16'h1);
    stall <= 1'b0;
    wait_done(1);
    @(posedge clk_i);
    per_req_i <= 4'h0;
    chk(n_wr - w0, 16'h4);
    chk(last_addr, 16'h0400);
    chk({8'h0, last_data}, 16'h00a6);
    chk(16'(n_crc - c0), 16'h4);
    chk(crc_sum - s0, 16'h0296);
  endtask
  task automatic t_error;
    logic [15:0] w0;
    w0 = n_wr;
    wr(6'h12, 16'h1000);
    wr(6'h13, 16'h0001);
    wr(6'h10, 16'h8001);
    wr(6'h15, 16'h0010);
    wait_done(2);
    chk(n_wr - w0, 16'h0);
    rd(6'h15, 16'h0004);
  endtask
  task automatic t_event;
    logic [15:0] w0;
    w0 = n_wr;
    @(posedge clk_i);
    slow <= 1'b1;
    wr(6'h19, 16'h1000);
    wr(6'h1a, 16'h0500);
    wr(6'h1b, 16'h0008);
    wr(6'h1c, 16'h00a7);
    wr(6'h18, 16'h6071);
    event_i <= 4'h8;
    repeat (6) @(posedge clk_i);
    event_i <= 4'h0;
    wait_done(3);
    @(posedge clk_i);
    slow <= 1'b0;
    chk(n_wr - w0, 16'h3);
    chk(last_addr, 16'h0502);
    rd(6'h1d, 16'h000a);
  endtask
  // channel 0 hands over to channel 1, which software left disabled
  task automatic t_link;
    logic [15:0] w0;
    w0 = n_wr;
    wr(6'h0d, 16'h0002);
    wr(6'h09, 16'h0600);
    wr(6'h0a, 16'h0700);
    wr(6'h0b, 16'h0002);
    wr(6'h08, 16'h4060);
    wr(6'h01, 16'h0800);
    wr(6'h02, 16'h0900);
    wr(6'h03, 16'h0001);
    wr(6'h00, 16'h0861);
    wr(6'h05, 16'h0010);
    wait_done(1);
    chk(n_wr - w0, 16'h3);
    chk(last_addr, 16'h0701);
    chk({8'h0, last_data}, 16'h00a4);
    rd(6'h05, 16'h0002);
  endtask
  // two channels fire on one event; the higher priority one drains first
  task automatic t_prio;
    logic [15:0] w0;
    w0 = n_wr;
    wr(6'h20, 16'h0003);
    rd(6'h20, 16'h0003);
    wr(6'h20, 16'h0000);
    wr(6'h15, 16'h000e);
    wr(6'h1d, 16'h000e);
    wr(6'h21, 16'h00c0);
    rd(6'h21, 16'h00c0);
    wr(6'h11, 16'h0a00);
    wr(6'h12, 16'h0b00);
    wr(6'h13, 16'h0002);
    wr(6'h10, 16'h4071);
    wr(6'h19, 16'h0c00);
    wr(6'h1a, 16'h0d00);
    wr(6'h1b, 16'h0002);
    wr(6'h18, 16'h0071);
    event_i <= 4'hc;
    repeat (6) @(posedge clk_i);
    event_i <= 4'h0;
    wait_done(2);
    chk(n_wr - w0, 16'h4);
    chk(last_addr, 16'h0b01);
    rd(6'h1d, 16'h0002);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_block();
    t_periph();
    t_error();
    t_event();
    t_link();
    t_prio();
    final_report();
  end
endmodule
`default_nettype wire
